// *** common/pll_serial_consts.svh ***
// constants for the three-wire tuning-chip control link, both ends
// assumes hclk at 20 MHz and an lsb-first 32-bit frame
// What this block does
// - two 24-bit control registers, 48 bits total
// - three lines: data, shift clock, strobe
// - frame is 8 address bits, 24 data
// - only addresses D0 to D3 answered
// - address D0 loads register one
// - address D2 loads register two
// - D1 and D3 return status or mirrors
// - strobe fall commits received word
// - read word captured on ninth falling edge
// - lines sampled on internal clock, oscillator gated
// - controller sends one throwaway frame first
// - crystal select matches fitted crystal
// - test bit always written zero
// - two port pins become counter inputs
// - counter-capable port pins reset as inputs
// - phase result on two parallel three-state outputs
// - reduced pin: second phase output becomes port
// - output port pins low after reset
// - crystal select resets to zero
`ifndef PLL_SERIAL_CONSTS_SVH
`define PLL_SERIAL_CONSTS_SVH

`define FRAME_BITS      6'd32
`define ADDR_BITS       6'd8
`define ADDR_REG_ONE    8'hD0
`define ADDR_STATUS     8'hD1
`define ADDR_REG_TWO    8'hD2
`define ADDR_PORTS      8'hD3
`define ADDR_THROWAWAY  8'h00
// register one fields
`define R1_DIV_LSB      0
`define R1_REF_LSB      16
`define R1_MODE_LSB     20
`define R1_XTAL_BIT     22
`define R1_RDSEL_BIT    23
// register two fields
`define R2_HFC_EN_BIT   5
`define R2_LFC_EN_BIT   6
`define R2_PHB_PORT_BIT 7
`define R2_TEST_BIT     9
`define R2_DIR_LSB      10
`define R2_OUT_LSB      15
`define REG_RESET       24'h000000
// controller register offsets
`define CTL_WDATA_OFS   8'h00
`define CTL_CMD_OFS     8'h04
`define CTL_RDATA_OFS   8'h08
`define CTL_STATUS_OFS  8'h0C
`define CMD_READ_BIT    8
// timing
`define CLK_NS          50
`define T_LEAD_NS       1000
`define T_GAP_NS        300
`define LEAD_CYC        ((`T_LEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC         ((`T_GAP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** common/pll_serial_pkg.sv ***
// types shared by both ends of the tuning-chip control link
// assumes pll_serial_consts.svh for the numbers
package pll_serial_pkg;
  typedef logic [23:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_LOW  = 6'h04,
    ST_HIGH = 6'h08,
    ST_TAIL = 6'h10,
    ST_GAP  = 6'h20
  } link_state_t;
endpackage

// *** common/serial_link_if.sv ***
// three-wire link between tuning controller and tuning device
// assumes a pull-up on the data line when neither end drives
`timescale 1ns/10ps
interface serial_link_if;
  logic shift_clk;
  logic strobe;
  logic ctl_data_out;
  logic ctl_data_oe_n;
  logic dev_data_out;
  logic dev_data_oe_n;
  wire  data_line;

  assign data_line = !ctl_data_oe_n ? ctl_data_out :
                     !dev_data_oe_n ? dev_data_out : 1'b1;

  modport ctl (output shift_clk, output strobe, output ctl_data_out,
               output ctl_data_oe_n, input data_line);
  modport dev (input shift_clk, input strobe, input data_line,
               output dev_data_out, output dev_data_oe_n);
endinterface

// *** rtl/pll_serial_device.sv ***
// device end: serial receiver, two control registers, readback and pins
// assumes link lines are asynchronous to hclk; shift clock idles high
`timescale 1ns/10ps
`include "pll_serial_consts.svh"
module pll_serial_device #(
  parameter bit REDUCED_PIN = 1'b0
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   osc_run,
  // link
  serial_link_if.dev                  link,
  // register one fields
  output      logic [15:0]            loop_divide,
  output      logic [3:0]             ref_select,
  output      logic [1:0]             input_mode,
  output      logic                   crystal_select,
  output      logic                   readback_select,
  // register two fields
  output      logic [8:0]             counter_control,
  output      logic                   test_mode,
  // counter and lock status
  input  wire logic [17:0]            counter_data,
  input  wire logic [1:0]             lock_status,
  // phase comparator
  input  wire logic                   phase_up,
  input  wire logic                   phase_down,
  output      logic                   phase_out_a,
  output      logic                   phase_out_a_oe_n,
  output      logic                   phase_out_b,
  output      logic                   phase_out_b_oe_n,
  // general ports
  output      logic [3:0]             general_output,
  input  wire logic [4:0]             io_in,
  output      logic [4:0]             io_out,
  output      logic [4:0]             io_oe_n,
  output      logic                   high_freq_count_in,
  output      logic                   low_freq_count_in
);
  import pll_serial_pkg::*;

  logic [2:0] clk_sync_reg;
  logic [2:0] stb_sync_reg;
  logic [1:0] dat_sync_reg;
  logic [1:0] osc_sync_reg;
  logic [4:0] io_s1_reg;
  logic [4:0] io_s2_reg;
  logic       rise;
  logic       fall;
  logic       stb_rise;
  logic       stb_fall;
  logic [31:0] shift_reg;
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  fall_cnt_reg;
  addr_t       addr_reg;
  logic        rd_active_reg;
  word_t       out_word_reg;
  word_t       reg_one_reg;
  word_t       reg_two_reg;
  word_t       rd_word;
  logic        phase_b_port;

  // first stage feeds only the second; edges come from later stages
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      clk_sync_reg <= 3'h7;
      stb_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h3;
      osc_sync_reg <= 2'h0;
    end
    else
    begin
      osc_sync_reg <= {osc_sync_reg[0], osc_run};
      clk_sync_reg <= {clk_sync_reg[1:0], link.shift_clk};
      stb_sync_reg <= {stb_sync_reg[1:0], link.strobe};
      dat_sync_reg <= {dat_sync_reg[0], link.data_line};
    end

  // stopped oscillator: no edge is seen, so nothing is taken in
  assign rise     = osc_sync_reg[1] && clk_sync_reg[1] && !clk_sync_reg[2];
  assign fall     = osc_sync_reg[1] && !clk_sync_reg[1] && clk_sync_reg[2];
  assign stb_rise = osc_sync_reg[1] && stb_sync_reg[1] && !stb_sync_reg[2];
  assign stb_fall = osc_sync_reg[1] && !stb_sync_reg[1] && stb_sync_reg[2];

  // receive shifter, lsb first, address byte first
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      shift_reg   <= 32'h00000000;
      bit_cnt_reg <= 6'h00;
      addr_reg    <= 8'h00;
    end
    else if (stb_rise)
    begin
      bit_cnt_reg <= 6'h00;
    end
    else if (rise && stb_sync_reg[1] && bit_cnt_reg != `FRAME_BITS)
    begin
      shift_reg   <= {dat_sync_reg[1], shift_reg[31:1]};
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg == `ADDR_BITS - 6'h01)
        addr_reg <= {dat_sync_reg[1], shift_reg[31:25]};
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      fall_cnt_reg <= 6'h00;
    else if (stb_rise)
      fall_cnt_reg <= 6'h00;
    else if (fall && stb_sync_reg[1] && fall_cnt_reg != 6'h3F)
      fall_cnt_reg <= fall_cnt_reg + 6'h01;

  // commit only on strobe fall after a whole frame
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      reg_one_reg <= `REG_RESET;
      reg_two_reg <= `REG_RESET;
    end
    else if (stb_fall && bit_cnt_reg == `FRAME_BITS)
    begin
      if (addr_reg == `ADDR_REG_ONE)
        reg_one_reg <= shift_reg[31:8];
      if (addr_reg == `ADDR_REG_TWO)
        reg_two_reg <= shift_reg[31:8];
    end

  always_comb
  begin
    rd_word = `REG_RESET;
    if (addr_reg == `ADDR_STATUS)
      rd_word = reg_one_reg[`R1_RDSEL_BIT] ? reg_one_reg
                : {4'h0, lock_status, counter_data};
    else if (addr_reg == `ADDR_PORTS)
      rd_word = {io_s2_reg, reg_two_reg[23:`R2_OUT_LSB],
                 reg_two_reg[`R2_TEST_BIT:0]};
  end

  // read side: load on ninth fall, then one bit per later fall
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_active_reg      <= 1'b0;
      out_word_reg       <= `REG_RESET;
      link.dev_data_out  <= 1'b1;
      link.dev_data_oe_n <= 1'b1;
    end
    else if (!stb_sync_reg[1])
    begin
      rd_active_reg      <= 1'b0;
      link.dev_data_oe_n <= 1'b1;
    end
    else if (fall && fall_cnt_reg == `ADDR_BITS)
    begin
      if (addr_reg == `ADDR_STATUS || addr_reg == `ADDR_PORTS)
      begin
        rd_active_reg      <= 1'b1;
        out_word_reg       <= {1'b0, rd_word[23:1]};
        link.dev_data_out  <= rd_word[0];
        link.dev_data_oe_n <= 1'b0;
      end
    end
    else if (fall && rd_active_reg)
    begin
      if (fall_cnt_reg == `FRAME_BITS)
      begin
        rd_active_reg      <= 1'b0;
        link.dev_data_oe_n <= 1'b1;
      end
      else
      begin
        link.dev_data_out <= out_word_reg[0];
        out_word_reg      <= {1'b0, out_word_reg[23:1]};
      end
    end

  // register fields to their pins
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      loop_divide     <= 16'h0000;
      ref_select      <= 4'h0;
      input_mode      <= 2'h0;
      crystal_select  <= 1'b0;
      readback_select <= 1'b0;
      counter_control <= 9'h000;
      test_mode       <= 1'b0;
    end
    else
    begin
      loop_divide     <= reg_one_reg[`R1_DIV_LSB +: 16];
      ref_select      <= reg_one_reg[`R1_REF_LSB +: 4];
      input_mode      <= reg_one_reg[`R1_MODE_LSB +: 2];
      crystal_select  <= reg_one_reg[`R1_XTAL_BIT];
      readback_select <= reg_one_reg[`R1_RDSEL_BIT];
      counter_control <= reg_two_reg[8:0];
      test_mode       <= reg_two_reg[`R2_TEST_BIT];
    end

  assign phase_b_port = REDUCED_PIN && reg_two_reg[`R2_PHB_PORT_BIT];

  // phase outputs: high on up, low on down, released otherwise; b as a port drives register two bit 18
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      phase_out_a      <= 1'b0;
      phase_out_a_oe_n <= 1'b1;
      phase_out_b      <= 1'b0;
      phase_out_b_oe_n <= 1'b1;
    end
    else
    begin
      phase_out_a      <= phase_up;
      phase_out_a_oe_n <= !(phase_up ^ phase_down);
      if (phase_b_port)
      begin
        phase_out_b      <= reg_two_reg[`R2_OUT_LSB + 3];
        phase_out_b_oe_n <= 1'b0;
      end
      else
      begin
        phase_out_b      <= phase_up;
        phase_out_b_oe_n <= !(phase_up ^ phase_down);
      end
    end

  // port pins; the two counter-capable pins are io 3 and 4
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      io_s1_reg          <= 5'h00;
      io_s2_reg          <= 5'h00;
      general_output     <= 4'h0;
      io_out             <= 5'h00;
      io_oe_n            <= 5'h1F;
      high_freq_count_in <= 1'b0;
      low_freq_count_in  <= 1'b0;
    end
    else
    begin
      io_s1_reg          <= io_in;
      io_s2_reg          <= io_s1_reg;
      general_output     <= reg_two_reg[`R2_OUT_LSB +: 4];
      io_out             <= reg_two_reg[`R2_OUT_LSB + 4 +: 5];
      io_oe_n            <= ~reg_two_reg[`R2_DIR_LSB +: 5];
      if (reg_two_reg[`R2_HFC_EN_BIT])
        io_oe_n[3] <= 1'b1;
      if (reg_two_reg[`R2_LFC_EN_BIT])
        io_oe_n[4] <= 1'b1;
      high_freq_count_in <= reg_two_reg[`R2_HFC_EN_BIT] && io_s2_reg[3];
      low_freq_count_in  <= reg_two_reg[`R2_LFC_EN_BIT] && io_s2_reg[4];
    end
endmodule

// *** rtl/pll_serial_controller.sv ***
// controller end: ahb-lite register slave driving the three-wire link
// assumes one ahb master, single word transfers; link clock made here
`timescale 1ns/10ps
`include "pll_serial_consts.svh"
module pll_serial_controller #(
  parameter int      HALF_CYC      = 4,
  parameter bit      CRYSTAL_7M2   = 1'b0
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output      logic [31:0]            hrdata,
  output      logic                   hreadyout,
  output      logic                   hresp,
  // link
  serial_link_if.ctl                  link
);
  import pll_serial_pkg::*;

  link_state_t state_reg;
  logic [7:0]  cnt_reg;
  logic [5:0]  bit_reg;
  logic [31:0] tx_reg;
  logic        is_read_reg;
  logic        first_reg;
  word_t       wdata_reg;
  word_t       rdata_reg;
  logic [1:0]  din_sync_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        go;
  logic [31:0] frame;
  word_t       payload;

  // address phase captured, write data used in the data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else if (hready)
    begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr;
      hrdata      <= 32'h00000000;
      if (hsel && htrans[1] && !hwrite)
        unique case (haddr)
          `CTL_WDATA_OFS:  hrdata <= {8'h00, wdata_reg};
          `CTL_RDATA_OFS:  hrdata <= {8'h00, rdata_reg};
          // pending throwaway frame counts as busy, or a poll at its start reads idle
          `CTL_STATUS_OFS: hrdata <= {31'h0, state_reg != ST_IDLE || first_reg};
          default:         hrdata <= 32'h00000000;
        endcase
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wdata_reg <= `REG_RESET;
    else if (wr_pend_reg && wr_addr_reg == `CTL_WDATA_OFS)
      wdata_reg <= hwdata[23:0];

  // command ignored while a frame runs
  assign go = (wr_pend_reg && wr_addr_reg == `CTL_CMD_OFS && state_reg == ST_IDLE)
              || first_reg;

  always_comb
  begin
    payload = wdata_reg;
    if (hwdata[7:0] == `ADDR_REG_ONE)
      payload[`R1_XTAL_BIT] = CRYSTAL_7M2;
    if (hwdata[7:0] == `ADDR_REG_TWO)
      payload[`R2_TEST_BIT] = 1'b0;
    frame = first_reg ? {`REG_RESET, `ADDR_THROWAWAY}
            : {payload, hwdata[7:0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      din_sync_reg <= 2'h3;
    else
      din_sync_reg <= {din_sync_reg[0], link.data_line};

  // link sequencer; clock idles high, data changes while low
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      state_reg          <= ST_IDLE;
      first_reg          <= 1'b1;
      cnt_reg            <= 8'h00;
      bit_reg            <= 6'h00;
      tx_reg             <= 32'h00000000;
      is_read_reg        <= 1'b0;
      rdata_reg          <= `REG_RESET;
      link.shift_clk     <= 1'b1;
      link.strobe        <= 1'b0;
      link.ctl_data_out  <= 1'b1;
      link.ctl_data_oe_n <= 1'b1;
    end
    else
      unique case (state_reg)
        ST_IDLE:
          if (go)
          begin
            first_reg   <= 1'b0;
            tx_reg      <= frame;
            is_read_reg <= !first_reg && hwdata[`CMD_READ_BIT];
            bit_reg     <= 6'h00;
            cnt_reg     <= 8'h00;
            link.strobe <= 1'b1;
            state_reg   <= ST_LEAD;
          end
        ST_LEAD:
          if (cnt_reg == 8'(`LEAD_CYC - 1))
          begin
            cnt_reg   <= 8'h00;
            state_reg <= ST_LOW;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        ST_LOW:
        begin
          if (cnt_reg == 8'h00)
          begin
            link.shift_clk     <= 1'b0;
            link.ctl_data_out  <= tx_reg[0];
            link.ctl_data_oe_n <= is_read_reg && bit_reg >= `ADDR_BITS;
            tx_reg             <= {1'b0, tx_reg[31:1]};
          end
          if (cnt_reg == 8'(HALF_CYC - 1))
          begin
            cnt_reg        <= 8'h00;
            link.shift_clk <= 1'b1;
            state_reg      <= ST_HIGH;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        end
        ST_HIGH:
          if (cnt_reg == 8'(HALF_CYC - 1))
          begin
            cnt_reg <= 8'h00;
            bit_reg <= bit_reg + 6'h01;
            if (is_read_reg && bit_reg >= `ADDR_BITS)
              rdata_reg <= {din_sync_reg[1], rdata_reg[23:1]};
            state_reg <= (bit_reg == `FRAME_BITS - 6'h01) ? ST_TAIL : ST_LOW;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        ST_TAIL:
          if (cnt_reg == 8'(`LEAD_CYC - 1))
          begin
            cnt_reg            <= 8'h00;
            link.strobe        <= 1'b0;
            link.ctl_data_oe_n <= 1'b1;
            state_reg          <= ST_GAP;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        ST_GAP:
          if (cnt_reg == 8'(`GAP_CYC - 1))
          begin
            cnt_reg   <= 8'h00;
            state_reg <= ST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 8'h01;
        default:
          state_reg <= ST_IDLE;
      endcase
endmodule

// *** dv/pll_serial_checker.sv ***
// wire-level checks on the three-wire link between controller and device
// assumes link outputs come from hclk registers; hresetn async, active low
`timescale 1ns/10ps
module pll_serial_checker (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic shift_clk,
  input wire logic strobe,
  input wire logic ctl_data_out,
  input wire logic ctl_data_oe_n,
  input wire logic dev_data_out,
  input wire logic dev_data_oe_n,
  input wire logic data_line
);
  logic       sck_q;
  logic       stb_q;
  logic [7:0] since_rise;
  logic [7:0] hi_run;
  logic [5:0] rise_cnt;
  logic [5:0] fall_cnt;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // counts survive strobe fall so the read release can still be judged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_q      <= 1'b1;
      stb_q      <= 1'b0;
      since_rise <= 8'h00;
      hi_run     <= 8'h00;
      rise_cnt   <= 6'h00;
      fall_cnt   <= 6'h00;
    end
    else
    begin
      sck_q      <= shift_clk;
      stb_q      <= strobe;
      since_rise <= !strobe ? 8'h00 : (since_rise == 8'hFF ? since_rise : since_rise + 8'h01);
      hi_run     <= (!strobe || !shift_clk) ? 8'h00 : (hi_run == 8'hFF ? hi_run : hi_run + 8'h01);
      if (strobe && !stb_q)
      begin
        rise_cnt <= 6'h00;
        fall_cnt <= 6'h00;
      end
      else if (strobe && sck_q && !shift_clk)
        fall_cnt <= fall_cnt + 6'h01;
      else if (strobe && !sck_q && shift_clk)
        rise_cnt <= rise_cnt + 6'h01;
    end
  end

  sequence low_phase;
    !shift_clk [*3] ##1 shift_clk;
  endsequence
  sequence high_phase;
    shift_clk [*4];
  endsequence

  a_clk_idle_high: assert property (!strobe |-> shift_clk)
    else $error("shift clock not high outside a frame");
  a_no_contention: assert property (!(!ctl_data_oe_n && !dev_data_oe_n))
    else $error("both ends drive the data line");
  a_dev_quiet_idle: assert property (!strobe [*8] |-> dev_data_oe_n)
    else $error("device drives data line between frames");
  a_lead_time: assert property ($fell(shift_clk) && fall_cnt == 6'h00 |-> since_rise >= 8'd20)
    else $error("first clock fall too soon after strobe rise");
  a_pulse_count: assert property ($fell(strobe) |-> rise_cnt == 6'd32)
    else $error("frame does not carry 32 clock pulses");
  a_low_half: assert property ($fell(shift_clk) |-> low_phase)
    else $error("shift clock low half not three cycles");
  a_high_half: assert property ($rose(shift_clk) && strobe |-> high_phase)
    else $error("shift clock high half too short");
  a_tail_time: assert property ($fell(strobe) |-> hi_run >= 8'd20)
    else $error("strobe falls too soon after last pulse");
  a_gap_time: assert property ($fell(strobe) |-> !strobe [*6])
    else $error("gap between frames too short");
  a_dev_read_window: assert property (!dev_data_oe_n |-> fall_cnt >= 6'd9)
    else $error("device drives before ninth clock fall");
  a_ctl_addr_drive: assert property (strobe && fall_cnt inside {[1:7]} |-> !ctl_data_oe_n)
    else $error("controller not driving address bits");
endmodule

// *** dv/tb_pll_serial_control_port.sv ***
// self-checking bench: ahb master, controller and device joined by the link
// assumes design files, package and serial_link_if compiled before this
`timescale 1ns/10ps
`include "pll_serial_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb_pll_serial_control_port;
  import pll_serial_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, osc_run;
  logic [7:0]  haddr;
  logic [1:0]  htrans, input_mode, lock_status;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, x;
  logic [15:0] loop_divide;
  logic [3:0]  ref_select, general_output;
  logic        crystal_select, readback_select, test_mode, phase_up, phase_down;
  logic [8:0]  counter_control;
  logic [17:0] counter_data;
  logic        phase_out_a, phase_out_a_oe_n, phase_out_b, phase_out_b_oe_n;
  logic [4:0]  io_in, io_out, io_oe_n;
  logic        high_freq_count_in, low_freq_count_in, pn, pb;
  logic [1:0]  pe;
  word_t       d1, d2, e, r, r1_pins;
  int          failures, total_checks, cyc;

  assign r1_pins = {readback_select, crystal_select, input_mode, ref_select, loop_divide};

  serial_link_if link ();
  pll_serial_controller i_pll_serial_controller (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link);
  pll_serial_device #(.REDUCED_PIN(1'b1)) i_pll_serial_device (.hclk, .hresetn, .osc_run,
    .link, .loop_divide, .ref_select, .input_mode, .crystal_select, .readback_select,
    .counter_control,
    .test_mode, .counter_data, .lock_status, .phase_up, .phase_down, .phase_out_a,
    .phase_out_a_oe_n, .phase_out_b, .phase_out_b_oe_n, .general_output, .io_in, .io_out,
    .io_oe_n, .high_freq_count_in, .low_freq_count_in);
  pll_serial_checker i_pll_serial_checker (.hclk, .hresetn, .shift_clk(link.shift_clk),
    .strobe(link.strobe), .ctl_data_out(link.ctl_data_out),
    .ctl_data_oe_n(link.ctl_data_oe_n), .dev_data_out(link.dev_data_out),
    .dev_data_oe_n(link.dev_data_oe_n), .data_line(link.data_line));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  task automatic give_verdict();
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // each frame is about 300 cycles; the whole run needs well under this
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      give_verdict();
    end
  end

  function automatic word_t exp1(word_t d);
    d[22] = 1'b0;
    return d;
  endfunction
  function automatic word_t exp2(word_t d);
    d[9] = 1'b0;
    return d;
  endfunction
  // counter-enabled pins must stay inputs whatever direction says
  function automatic logic [4:0] exp_oe(word_t w);
    logic [4:0] oe;
    oe = ~w[14:10];
    oe[3] = oe[3] | w[5];
    oe[4] = oe[4] | w[6];
    return oe;
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // a hang here is ended by the bench timeout, which counts it
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    while (s[0] !== 1'b0)
      ahb(1'b0, `CTL_STATUS_OFS, 32'h0, s);
    repeat (4) @(posedge hclk);
  endtask

  task automatic frame(input logic rd_f, input addr_t a, input word_t d, output word_t q);
    logic [31:0] y;
    ahb(1'b1, `CTL_WDATA_OFS, {8'h00, d}, y);
    ahb(1'b1, `CTL_CMD_OFS, {23'h0, rd_f, a}, y);
    repeat (4) @(posedge hclk);
    wait_idle();
    ahb(1'b0, `CTL_RDATA_OFS, 32'h0, y);
    q = y[23:0];
  endtask

  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, phase_up, phase_down} = '0;
    {counter_data, lock_status, io_in} = '0;
    hsize = 3'h2;
    osc_run = 1'b1;
    void'($urandom(32'hF826C95A));
    repeat (10) @(posedge hclk);
    `CHK({crystal_select, general_output}, 5'h00)
    `CHK(io_oe_n, 5'h1F)
    hresetn <= 1'b1;
    wait_idle();
    for (int i = 0; i < 4; i++)
    begin
      d1 = i == 0 ? 24'hFFFFFF : word_t'($urandom);
      d2 = i == 0 ? 24'hFFFFFF : (i == 1 ? 24'h000000 : word_t'($urandom));
      d1[23] = i == 1 ? 1'b0 : d1[23];
      counter_data <= 18'($urandom);
      lock_status <= 2'($urandom);
      io_in <= 5'($urandom);
      frame(1'b0, `ADDR_REG_ONE, d1, r);
      `CHK(r1_pins, exp1(d1))
      frame(1'b0, `ADDR_REG_TWO, d2, r);
      e = exp2(d2);
      `CHK({io_out, general_output, test_mode, counter_control}, {e[23:15], e[9:0]})
      `CHK(io_oe_n, exp_oe(e))
      `CHK({low_freq_count_in, high_freq_count_in}, {e[6] & io_in[4], e[5] & io_in[3]})
      frame(1'b1, `ADDR_STATUS, 24'h0, r);
      `CHK(r, d1[23] ? exp1(d1) : {4'h0, lock_status, counter_data})
      frame(1'b1, `ADDR_PORTS, 24'h0, r);
      `CHK(r, {io_in, e[23:15], e[9:0]})
    end
    frame(1'b0, 8'hD5, ~d1, r);
    `CHK(r1_pins, exp1(d1))
    osc_run <= 1'b0;
    repeat (4) @(posedge hclk);
    frame(1'b0, `ADDR_REG_ONE, ~d1, r);
    `CHK(r1_pins, exp1(d1))
    osc_run <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h40, 32'h0, x);
    `CHK({hresp, x}, 33'h000000000)
    // second half turns the second phase output into port bit 18, set high
    for (int k = 0; k < 8; k++)
    begin
      if (k[1:0] == 2'h0)
        frame(1'b0, `ADDR_REG_TWO, k[2] ? 24'h040080 : 24'h040000, r);
      {phase_up, phase_down} <= 2'(k);
      repeat (3) @(posedge hclk);
      pn = ~(phase_up ^ phase_down);
      pb = k[2];
      pe = pb ? 2'b01 : {pn, phase_up & ~pn};
      `CHK({phase_out_a_oe_n, phase_out_a & ~pn}, {pn, phase_up & ~pn})
      `CHK({phase_out_b_oe_n, phase_out_b & ~(pn & ~pb)}, pe)
    end
    give_verdict();
  end
endmodule
